// >>> rtl/iots_pkg.sv
// constants and types for the timer-skip and port instruction unit
// What this block does
// - timer-1 enable low, flag set: skip, clear
// - timer-2 enable low, flag set: skip, clear
// - timer-3 enable low, flag set: skip, clear
// - timer-4 enable low, flag set: skip, clear
// - port zero input pins into accumulator
// - accumulator into port zero output latch
// - port one input pins into accumulator
// - accumulator into port one output latch
// - port two input pins into accumulator
// - accumulator into port two output latch
// - port three input pins into accumulator
// - accumulator into port three output latch
// - port six input pins into accumulator
// - accumulator into port six output latch
// - set every discrete port bit to one
// - clear only the discrete bit Y selects
// - set only the discrete bit Y selects
// - skip when selected discrete bit is zero
// - single-bit port cleared or set by opcode
// - first pull-up register read and written
// - second pull-up register written and read
// - port two read forces accumulator top bit zero
package iots_pkg;
  // axi4-lite byte offsets
  localparam logic [3:0] OFS_IRQ_CTRL = 4'h0; // [3:0] first, [7:4] second
  localparam logic [3:0] OFS_TFLAGS   = 4'h4; // timer flags, write 1 clears
  localparam logic [3:0] OFS_PULLUP   = 4'h8; // [3:0] first, [7:4] second
  localparam logic [3:0] OFS_PORTS    = 4'hc; // [6:0] discrete, [8] single
  // field positions of the timer enables in the packed control vector
  localparam int T1_IE_POS = 2; // bit 2 of first control register
  localparam int T2_IE_POS = 3; // bit 3 of first control register
  localparam int T3_IE_POS = 4; // bit 0 of second control register
  localparam int T4_IE_POS = 5; // bit 1 of second control register
  localparam int DBIT_MAX  = 6; // highest valid discrete bit index
  // reset values
  localparam logic [7:0] IRQ_CTRL_RST = 8'h00;
  localparam logic [7:0] PULLUP_RST   = 8'h00;
  localparam logic [6:0] DPORT_RST    = 7'h00;
  localparam logic [1:0] RESP_OKAY    = 2'h0;
  localparam logic [1:0] RESP_SLVERR  = 2'h2;

  typedef enum logic [4:0] {
    CMD_NOP     = 5'h00,
    CMD_SKIP_T1 = 5'h01,
    CMD_SKIP_T2 = 5'h02,
    CMD_SKIP_T3 = 5'h03,
    CMD_SKIP_T4 = 5'h04,
    CMD_IN_P0   = 5'h05,
    CMD_OUT_P0  = 5'h06,
    CMD_IN_P1   = 5'h07,
    CMD_OUT_P1  = 5'h08,
    CMD_IN_P2   = 5'h09,
    CMD_OUT_P2  = 5'h0a,
    CMD_IN_P3   = 5'h0b,
    CMD_OUT_P3  = 5'h0c,
    CMD_IN_P6   = 5'h0d,
    CMD_OUT_P6  = 5'h0e,
    CMD_SET_D   = 5'h0f,
    CMD_CLR_DB  = 5'h10,
    CMD_SET_DB  = 5'h11,
    CMD_TEST_DB = 5'h12,
    CMD_CLR_C   = 5'h13,
    CMD_SET_C   = 5'h14,
    CMD_RD_PU0  = 5'h15,
    CMD_WR_PU0  = 5'h16,
    CMD_RD_PU1  = 5'h17,
    CMD_WR_PU1  = 5'h18
  } iots_cmd_t;
endpackage : iots_pkg

// >>> rtl/iots_unit.sv
// timer-flag skip and port transfer instruction unit with axi4-lite regs
//
// Decided for this implementation: the register addresses and the AXI4-Lite register port.
`timescale 1ns/1ps
module iots_unit import iots_pkg::*; (
  input  wire logic        clk,           // core clock, 25 MHz
  input  wire logic        resetn,        // async reset, active low
  input  wire logic        exec_valid,    // one instruction this cycle
  input  wire iots_cmd_t   exec_cmd,      // decoded instruction
  input  wire logic [3:0]  acc_in,        // accumulator contents
  input  wire logic [3:0]  y_in,          // index register
  input  wire logic [3:0]  tmr_evt,       // timer 1..4 underflow pulses
  output logic             acc_we,        // load accumulator, pulse
  output logic [3:0]       acc_out,       // new accumulator value
  output logic             skip_next,     // next instruction skipped
  input  wire logic [3:0]  p0_in,         // port zero pins
  input  wire logic [3:0]  p1_in,         // port one pins
  input  wire logic [2:0]  p2_in,         // port two pins
  input  wire logic [3:0]  p3_in,         // port three pins
  input  wire logic [3:0]  p6_in,         // port six pins
  output logic [3:0]       p0_out,        // port zero latch
  output logic [3:0]       p1_out,        // port one latch
  output logic [2:0]       p2_out,        // port two latch
  output logic [3:0]       p3_out,        // port three latch
  output logic [3:0]       p6_out,        // port six latch
  output logic [6:0]       d_out,         // discrete port latch
  output logic             c_out,         // single-bit port
  output logic [3:0]       pu0_out,       // first pull-up control
  output logic [3:0]       pu1_out,       // second pull-up control
  input  wire logic [3:0]  s_axi_awaddr,  // write address
  input  wire logic        s_axi_awvalid, // write address valid
  output logic             s_axi_awready, // write address ready
  input  wire logic [31:0] s_axi_wdata,   // write data
  input  wire logic [3:0]  s_axi_wstrb,   // write strobes
  input  wire logic        s_axi_wvalid,  // write data valid
  output logic             s_axi_wready,  // write data ready
  output logic [1:0]       s_axi_bresp,   // write response
  output logic             s_axi_bvalid,  // write response valid
  input  wire logic        s_axi_bready,  // write response ready
  input  wire logic [3:0]  s_axi_araddr,  // read address
  input  wire logic        s_axi_arvalid, // read address valid
  output logic             s_axi_arready, // read address ready
  output logic [31:0]      s_axi_rdata,   // read data
  output logic [1:0]       s_axi_rresp,   // read response
  output logic             s_axi_rvalid,  // read data valid
  input  wire logic        s_axi_rready   // read data ready
);

  typedef struct packed {
    logic [18:0] pin_s1;
    logic [18:0] pin_s2;
    logic [3:0]  tflag;
    logic [7:0]  irq_ctrl;
    logic        skip_pend;
    logic        acc_we;
    logic [3:0]  acc;
    logic        skip;
    logic [3:0]  p0;
    logic [3:0]  p1;
    logic [2:0]  p2;
    logic [3:0]  p3;
    logic [3:0]  p6;
    logic [6:0]  d;
    logic        c;
    logic [7:0]  pu;
    logic        awready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [1:0]  rresp;
    logic [31:0] rdata;
  } iots_state_t;

  localparam iots_state_t STATE_RST = '{
    irq_ctrl: IRQ_CTRL_RST, pu: PULLUP_RST, d: DPORT_RST, default: '0};

  iots_state_t q;
  iots_state_t d;

  logic [3:0] ie_vec;
  logic       go;
  logic [3:0] tclr;
  logic [3:0] sw_clr;
  logic [3:0] sp0;
  logic [3:0] sp1;
  logic [2:0] sp2;
  logic [3:0] sp3;
  logic [3:0] sp6;

  assign ie_vec = {q.irq_ctrl[T4_IE_POS], q.irq_ctrl[T3_IE_POS],
                   q.irq_ctrl[T2_IE_POS], q.irq_ctrl[T1_IE_POS]};
  // a skipped slot still arrives as exec_valid and is swallowed
  assign go = exec_valid && !q.skip_pend;
  assign {sp6, sp3, sp2, sp1, sp0} = q.pin_s2;

  always_comb begin
    d        = q;
    tclr     = 4'h0;
    sw_clr   = 4'h0;
    d.acc_we = 1'b0;
    d.skip   = 1'b0;
    d.pin_s1 = {p6_in, p3_in, p2_in, p1_in, p0_in};
    d.pin_s2 = q.pin_s1;
    if (exec_valid && q.skip_pend) begin
      d.skip_pend = 1'b0;
    end
    if (go) begin
      unique case (exec_cmd)
        CMD_SKIP_T1: tclr[0] = !ie_vec[0] && q.tflag[0];
        CMD_SKIP_T2: tclr[1] = !ie_vec[1] && q.tflag[1];
        CMD_SKIP_T3: tclr[2] = !ie_vec[2] && q.tflag[2];
        CMD_SKIP_T4: tclr[3] = !ie_vec[3] && q.tflag[3];
        CMD_IN_P0: begin
          d.acc    = sp0;
          d.acc_we = 1'b1;
        end
        CMD_IN_P1: begin
          d.acc    = sp1;
          d.acc_we = 1'b1;
        end
        CMD_IN_P2: begin
          d.acc    = {1'b0, sp2};
          d.acc_we = 1'b1;
        end
        CMD_IN_P3: begin
          d.acc    = sp3;
          d.acc_we = 1'b1;
        end
        CMD_IN_P6: begin
          d.acc    = sp6;
          d.acc_we = 1'b1;
        end
        CMD_OUT_P0: d.p0 = acc_in;
        CMD_OUT_P1: d.p1 = acc_in;
        CMD_OUT_P2: d.p2 = acc_in[2:0];
        CMD_OUT_P3: d.p3 = acc_in;
        CMD_OUT_P6: d.p6 = acc_in;
        CMD_SET_D: d.d = 7'h7f;
        CMD_CLR_DB: begin
          // index above the last bit leaves the port alone
          if (y_in <= 4'(DBIT_MAX)) d.d[y_in[2:0]] = 1'b0;
        end
        CMD_SET_DB: begin
          if (y_in <= 4'(DBIT_MAX)) d.d[y_in[2:0]] = 1'b1;
        end
        CMD_TEST_DB: begin
          if (y_in <= 4'(DBIT_MAX) && !q.d[y_in[2:0]]) begin
            d.skip      = 1'b1;
            d.skip_pend = 1'b1;
          end
        end
        CMD_CLR_C: d.c = 1'b0;
        CMD_SET_C: d.c = 1'b1;
        CMD_RD_PU0: begin
          d.acc    = q.pu[3:0];
          d.acc_we = 1'b1;
        end
        CMD_WR_PU0: d.pu[3:0] = acc_in;
        CMD_RD_PU1: begin
          d.acc    = q.pu[7:4];
          d.acc_we = 1'b1;
        end
        CMD_WR_PU1: d.pu[7:4] = acc_in;
        default: ;
      endcase
      if (tclr != 4'h0) begin
        d.skip      = 1'b1;
        d.skip_pend = 1'b1;
      end
    end

    // axi write: ready for one cycle once both channels are offered
    d.awready = 1'b0;
    if (s_axi_awvalid && s_axi_wvalid && !q.awready && !q.bvalid) begin
      d.awready = 1'b1;
    end
    if (q.awready) begin
      d.bvalid = 1'b1;
      d.bresp  = RESP_OKAY;
      unique case (s_axi_awaddr)
        OFS_IRQ_CTRL: begin
          if (s_axi_wstrb[0]) d.irq_ctrl = s_axi_wdata[7:0];
        end
        OFS_TFLAGS: begin
          if (s_axi_wstrb[0]) sw_clr = s_axi_wdata[3:0];
        end
        OFS_PULLUP, OFS_PORTS: ; // read only, writes ignored
        default: d.bresp = RESP_SLVERR;
      endcase
    end else if (q.bvalid && s_axi_bready) begin
      d.bvalid = 1'b0;
    end

    // axi read
    d.arready = 1'b0;
    if (s_axi_arvalid && !q.arready && !q.rvalid) begin
      d.arready = 1'b1;
    end
    if (q.arready) begin
      d.rvalid = 1'b1;
      d.rresp  = RESP_OKAY;
      d.rdata  = 32'h0;
      unique case (s_axi_araddr)
        OFS_IRQ_CTRL: d.rdata[7:0] = q.irq_ctrl;
        OFS_TFLAGS:   d.rdata[3:0] = q.tflag;
        OFS_PULLUP:   d.rdata[7:0] = q.pu;
        OFS_PORTS:    d.rdata[8:0] = {q.c, 1'b0, q.d};
        default:      d.rresp      = RESP_SLVERR;
      endcase
    end else if (q.rvalid && s_axi_rready) begin
      d.rvalid = 1'b0;
    end

    // a new underflow in the clearing cycle survives the clear
    d.tflag = (q.tflag & ~(tclr | sw_clr)) | tmr_evt;
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      q <= STATE_RST;
    end else begin
      q <= d;
    end
  end

  assign acc_we        = q.acc_we;
  assign acc_out       = q.acc;
  assign skip_next     = q.skip;
  assign p0_out        = q.p0;
  assign p1_out        = q.p1;
  assign p2_out        = q.p2;
  assign p3_out        = q.p3;
  assign p6_out        = q.p6;
  assign d_out         = q.d;
  assign c_out         = q.c;
  assign pu0_out       = q.pu[3:0];
  assign pu1_out       = q.pu[7:4];
  assign s_axi_awready = q.awready;
  assign s_axi_wready  = q.awready;
  assign s_axi_bvalid  = q.bvalid;
  assign s_axi_bresp   = q.bresp;
  assign s_axi_arready = q.arready;
  assign s_axi_rvalid  = q.rvalid;
  assign s_axi_rresp   = q.rresp;
  assign s_axi_rdata   = q.rdata;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  a_t1_skip_clr: assert property (
    go && exec_cmd == CMD_SKIP_T1 && !ie_vec[0] && q.tflag[0] && !tmr_evt[0]
    |=> skip_next && !q.tflag[0])
    else $error("timer 1 skip did not skip and clear");
  a_t2_skip_clr: assert property (
    go && exec_cmd == CMD_SKIP_T2 && !ie_vec[1] && q.tflag[1] && !tmr_evt[1]
    |=> skip_next && !q.tflag[1])
    else $error("timer 2 skip did not skip and clear");
  a_t3_enabled_nop: assert property (
    go && exec_cmd == CMD_SKIP_T3 && ie_vec[2] && !sw_clr[2]
    |=> !skip_next && q.tflag[2] == ($past(q.tflag[2]) | $past(tmr_evt[2])))
    else $error("timer 3 skip acted while enabled");
  a_t4_skip_clr: assert property (
    go && exec_cmd == CMD_SKIP_T4 && !ie_vec[3] && q.tflag[3] && !tmr_evt[3]
    |=> skip_next && !q.tflag[3])
    else $error("timer 4 skip did not skip and clear");
  a_in_port0: assert property (
    go && exec_cmd == CMD_IN_P0 |=> acc_we && acc_out == $past(sp0))
    else $error("port zero read wrong");
  a_out_port0: assert property (
    go && exec_cmd == CMD_OUT_P0 |=> p0_out == $past(acc_in))
    else $error("port zero latch wrong");
  a_in_port2: assert property (
    go && exec_cmd == CMD_IN_P2 |=> acc_we && acc_out == {1'b0, $past(sp2)})
    else $error("port two read wrong");
  a_set_all_d: assert property (
    go && exec_cmd == CMD_SET_D |=> d_out == 7'h7f)
    else $error("discrete port not all ones");
  a_clr_d_bit: assert property (
    go && exec_cmd == CMD_CLR_DB && y_in < 4'h7
    |=> d_out == ($past(d_out) & ~(7'h01 << $past(y_in[2:0]))))
    else $error("discrete bit clear wrong");
  a_test_d_bit: assert property (
    go && exec_cmd == CMD_TEST_DB && y_in < 4'h7
    |=> skip_next == ((($past(d_out) >> $past(y_in[2:0])) & 7'h01) == 7'h00))
    else $error("discrete bit test wrong");
  a_skipped_nop: assert property (
    exec_valid && q.skip_pend
    |=> !acc_we && !skip_next && $stable(d_out) && $stable(p0_out)
        && $stable(c_out) && $stable(pu0_out))
    else $error("skipped instruction changed state");

  // the same skip checks for the remaining timers and enable states
  a_t3_skip_clr: assert property (
    go && exec_cmd == CMD_SKIP_T3 && !ie_vec[2] && q.tflag[2] && !tmr_evt[2]
    |=> skip_next && !q.tflag[2])
    else $error("timer 3 skip did not skip and clear");
  a_t1_enabled_nop: assert property (
    go && exec_cmd == CMD_SKIP_T1 && ie_vec[0] && !sw_clr[0]
    |=> !skip_next && q.tflag[0] == ($past(q.tflag[0]) | $past(tmr_evt[0])))
    else $error("timer 1 skip acted while enabled");
  a_t2_enabled_nop: assert property (
    go && exec_cmd == CMD_SKIP_T2 && ie_vec[1] && !sw_clr[1]
    |=> !skip_next && q.tflag[1] == ($past(q.tflag[1]) | $past(tmr_evt[1])))
    else $error("timer 2 skip acted while enabled");
  a_t4_enabled_nop: assert property (
    go && exec_cmd == CMD_SKIP_T4 && ie_vec[3] && !sw_clr[3]
    |=> !skip_next && q.tflag[3] == ($past(q.tflag[3]) | $past(tmr_evt[3])))
    else $error("timer 4 skip acted while enabled");
  // an underflow always lands, even against a clear in the same cycle
  a_flag_set_wins: assert property (
    tmr_evt != 4'h0 |=> (q.tflag & $past(tmr_evt)) == $past(tmr_evt))
    else $error("timer underflow lost");
  // transfers between the accumulator and the ports
  a_in_port1: assert property (
    go && exec_cmd == CMD_IN_P1 |=> acc_we && acc_out == $past(sp1))
    else $error("port one read wrong");
  a_in_port3: assert property (
    go && exec_cmd == CMD_IN_P3 |=> acc_we && acc_out == $past(sp3))
    else $error("port three read wrong");
  a_in_port6: assert property (
    go && exec_cmd == CMD_IN_P6 |=> acc_we && acc_out == $past(sp6))
    else $error("port six read wrong");
  a_out_port1: assert property (
    go && exec_cmd == CMD_OUT_P1 |=> p1_out == $past(acc_in))
    else $error("port one latch wrong");
  a_out_port2: assert property (
    go && exec_cmd == CMD_OUT_P2 |=> p2_out == $past(acc_in[2:0]))
    else $error("port two latch wrong");
  a_out_port3: assert property (
    go && exec_cmd == CMD_OUT_P3 |=> p3_out == $past(acc_in))
    else $error("port three latch wrong");
  a_out_port6: assert property (
    go && exec_cmd == CMD_OUT_P6 |=> p6_out == $past(acc_in))
    else $error("port six latch wrong");
  // discrete, single-bit and pull-up registers
  a_set_d_bit: assert property (
    go && exec_cmd == CMD_SET_DB && y_in < 4'h7
    |=> d_out == ($past(d_out) | (7'h01 << $past(y_in[2:0]))))
    else $error("discrete bit set wrong");
  a_d_idx_high: assert property (
    go && (exec_cmd == CMD_CLR_DB || exec_cmd == CMD_SET_DB) && y_in > 4'h6
    |=> $stable(d_out))
    else $error("discrete port changed by bad index");
  a_clr_c_port: assert property (
    go && exec_cmd == CMD_CLR_C |=> !c_out)
    else $error("single-bit port not cleared");
  a_set_c_port: assert property (
    go && exec_cmd == CMD_SET_C |=> c_out)
    else $error("single-bit port not set");
  a_rd_pullup0: assert property (
    go && exec_cmd == CMD_RD_PU0 |=> acc_we && acc_out == $past(pu0_out))
    else $error("first pull-up read wrong");
  a_wr_pullup0: assert property (
    go && exec_cmd == CMD_WR_PU0 |=> pu0_out == $past(acc_in))
    else $error("first pull-up write wrong");
  a_rd_pullup1: assert property (
    go && exec_cmd == CMD_RD_PU1 |=> acc_we && acc_out == $past(pu1_out))
    else $error("second pull-up read wrong");
  a_wr_pullup1: assert property (
    go && exec_cmd == CMD_WR_PU1 |=> pu1_out == $past(acc_in))
    else $error("second pull-up write wrong");
  // a skip swallows exactly one slot, never two
  a_skip_one_slot: assert property (
    skip_next |=> !skip_next)
    else $error("skip raised twice in a row");
  // bus answers stand until taken, ready pulses for one cycle
  a_aw_one_cycle: assert property (
    s_axi_awready |=> !s_axi_awready)
    else $error("write ready held too long");
  a_ar_one_cycle: assert property (
    s_axi_arready |=> !s_axi_arready)
    else $error("read ready held too long");
  a_bvalid_hold: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped early");
  a_rvalid_hold: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read response dropped early");

endmodule : iots_unit

// >>> sim/iots_core_model.sv
// stand-in for the core accumulator that takes the unit's loads
`timescale 1ns/1ps
module iots_core_model (
  clk,    // core clock
  resetn, // async reset, active low
  acc_we, // load strobe from the unit
  acc_out, // value to load
  acc_q   // accumulator as the core sees it
);
  input  wire logic       clk;
  input  wire logic       resetn;
  input  wire logic       acc_we;
  input  wire logic [3:0] acc_out;
  output logic      [3:0] acc_q;
  // only loads on the strobe, so a stray value on acc_out is harmless
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) acc_q <= 4'h0;
    else if (acc_we) acc_q <= acc_out;
  end
endmodule : iots_core_model

// >>> sim/io_timer_skip_instr_exec_bench.sv
// self-checking bench for the timer-skip and port instruction unit
`timescale 1ns/1ps
module io_timer_skip_instr_exec_bench;
  import iots_pkg::*;
  logic clk = 0, resetn = 0, ev = 0, awv = 0, wv = 0, br = 0, arv = 0, rr = 0;
  logic [3:0] acc = 0, y = 0, tev = 0, aa = 0, ra = 0, ws = 4'hf;
  logic [18:0] pins = 0;
  logic [31:0] wd = 0, rdat, rd;
  iots_cmd_t cmd = CMD_NOP;
  logic we, skp, c, awr, wr, bv, arr, rv;
  logic [3:0] ao, u0, u1, accq, x, x0;
  logic [18:0] po;
  logic [6:0] d, dx;
  logic [1:0] bre, rre;
  logic [4:0] q[$], e;
  int err_total = 0, checks_done = 0;
  int m;
  int lo[5] = '{0, 4, 8, 11, 15};
  iots_cmd_t oc[5] = '{CMD_OUT_P0, CMD_OUT_P1, CMD_OUT_P2, CMD_OUT_P3,
                       CMD_OUT_P6};
  iots_cmd_t ic[5] = '{CMD_IN_P0, CMD_IN_P1, CMD_IN_P2, CMD_IN_P3, CMD_IN_P6};
  iots_unit u_iots_unit (.clk(clk), .resetn(resetn), .exec_valid(ev),
    .exec_cmd(cmd), .acc_in(acc), .y_in(y), .tmr_evt(tev), .acc_we(we),
    .acc_out(ao), .skip_next(skp), .p0_in(pins[3:0]), .p1_in(pins[7:4]),
    .p2_in(pins[10:8]), .p3_in(pins[14:11]), .p6_in(pins[18:15]),
    .p0_out(po[3:0]), .p1_out(po[7:4]), .p2_out(po[10:8]),
    .p3_out(po[14:11]), .p6_out(po[18:15]), .d_out(d), .c_out(c),
    .pu0_out(u0), .pu1_out(u1), .s_axi_awaddr(aa), .s_axi_awvalid(awv),
    .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(ws),
    .s_axi_wvalid(wv), .s_axi_wready(wr), .s_axi_bresp(bre),
    .s_axi_bvalid(bv), .s_axi_bready(br), .s_axi_araddr(ra),
    .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdat),
    .s_axi_rresp(rre), .s_axi_rvalid(rv), .s_axi_rready(rr));
  iots_core_model u_iots_core_model (.clk(clk), .resetn(resetn),
    .acc_we(we), .acc_out(ao), .acc_q(accq));
  always #20 clk = ~clk;
  task final_report;
    if (err_total == 0 && checks_done > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : final_report
  task chk(logic [31:0] g, logic [31:0] ex);
    checks_done++;
    if (g !== ex) begin
      err_total++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, g, ex);
    end
  endtask : chk
  task tmo(int n);
    if (n >= 50) begin
      err_total++;
      final_report;
    end
  endtask : tmo
  // each result pops the oldest note: {skip, accumulator}
  always @(negedge clk) begin
    if (we === 1'b1 || skp === 1'b1) begin
      e = q.size() ? q.pop_front() : 5'bx;
      chk({skp, we ? ao : 4'h0}, e);
    end
  end
  task ex(iots_cmd_t c_, logic [3:0] a_, logic [3:0] y_);
    @(posedge clk);
    ev <= 1;
    cmd <= c_;
    acc <= a_;
    y <= y_;
  endtask : ex
  task idl(int n);
    @(posedge clk);
    ev <= 0;
    repeat (n) @(posedge clk);
  endtask : idl
  task axi_wr(logic [3:0] a, logic [31:0] v);
    int n;
    bit ga, gw;
    @(posedge clk);
    aa <= a; wd <= v; awv <= 1; wv <= 1; br <= 1;
    ga = 0; gw = 0; n = 0;
    while (!(ga && gw) && n < 50) begin
      @(posedge clk);
      n++;
      if (!ga && awr === 1'b1) begin ga = 1; awv <= 0; end
      if (!gw && wr === 1'b1) begin gw = 1; wv <= 0; end
    end
    tmo(n);
    n = 0;
    while (bv !== 1'b1 && n < 50) begin @(posedge clk); n++; end
    br <= 0;
    tmo(n);
    chk(bre, RESP_OKAY);
  endtask : axi_wr
  task axi_rd(logic [3:0] a);
    int n;
    @(posedge clk);
    ra <= a; arv <= 1; rr <= 1;
    n = 0;
    do begin @(posedge clk); n++; end while (arr !== 1'b1 && n < 50);
    arv <= 0;
    tmo(n);
    n = 0;
    while (rv !== 1'b1 && n < 50) begin @(posedge clk); n++; end
    rr <= 0;
    rd = rdat;
    tmo(n);
    chk(rre, RESP_OKAY);
  endtask : axi_rd
  initial begin
    void'($urandom(57570));
    repeat (3) @(posedge clk);
    resetn <= 1;
    @(posedge clk);
    chk({d, c, u0, u1}, 0);
    chk(po, 0);
    for (int i = 0; i < 4; i++) begin
      // enable high holds the flag but must not skip
      axi_wr(OFS_IRQ_CTRL, 32'h1 << (T1_IE_POS + i));
      @(posedge clk); tev <= 4'h1 << i;
      @(posedge clk); tev <= 4'h0;
      ex(iots_cmd_t'(CMD_SKIP_T1 + i), 0, 0);
      idl(1);
      axi_wr(OFS_IRQ_CTRL, 0);
      q.push_back(5'h10);
      ex(iots_cmd_t'(CMD_SKIP_T1 + i), 0, 0);
      ex(CMD_OUT_P0, 4'hf, 0);
      ex(iots_cmd_t'(CMD_SKIP_T1 + i), 0, 0);
      idl(1);
      chk(po[3:0], 0);
    end
    @(posedge clk);
    tev <= 4'h5;
    @(posedge clk);
    tev <= 4'h0;
    axi_rd(OFS_TFLAGS);
    chk(rd, 32'h5);
    axi_wr(OFS_TFLAGS, 32'h5);
    axi_rd(OFS_TFLAGS);
    chk(rd, 32'h0);
    for (int i = 0; i < 5; i++) begin
      x = 4'($urandom);
      m = (i == 2) ? 7 : 15;
      ex(oc[i], x, 0);
      idl(1);
      chk((po >> lo[i]) & m, x & m);
      @(posedge clk);
      pins <= 19'($urandom);
      repeat (3) @(posedge clk);
      q.push_back(5'((pins >> lo[i]) & m));
      ex(ic[i], 0, 0);
      idl(1);
    end
    ex(CMD_SET_D, 0, 0);
    idl(1);
    dx = 7'h7f;
    chk(d, dx);
    for (int k = 0; k < 8; k++) begin
      ex(CMD_CLR_DB, 0, k);
      idl(1);
      if (k < 7) dx[k] = 0;
      chk(d, dx);
      if (k == 7) continue;
      q.push_back(5'h10);
      ex(CMD_TEST_DB, 0, k);
      ex(CMD_SET_DB, 0, k);
      idl(1);
      chk(d, dx);
      if (k[0]) continue;
      ex(CMD_SET_DB, 0, k);
      ex(CMD_TEST_DB, 0, k);
      idl(1);
      dx[k] = 1;
      chk(d, dx);
    end
    ex(CMD_SET_C, 0, 0);
    idl(1);
    chk(c, 1);
    axi_rd(OFS_PORTS);
    chk(rd, {23'h0, 1'b1, 1'b0, dx});
    ex(CMD_CLR_C, 0, 0);
    idl(1);
    chk(c, 0);
    for (int k = 0; k < 2; k++) begin
      x = 4'($urandom);
      if (k == 0) x0 = x;
      ex(k ? CMD_WR_PU1 : CMD_WR_PU0, x, 0);
      q.push_back({1'b0, x});
      ex(k ? CMD_RD_PU1 : CMD_RD_PU0, 0, 0);
      idl(2);
      chk(k ? u1 : u0, x);
      chk(accq, x);
    end
    axi_rd(OFS_PULLUP);
    chk(rd[7:0], {x, x0});
    chk(q.size(), 0);
    final_report;
  end
endmodule : io_timer_skip_instr_exec_bench
